// file: lftw_bus_model.sv
// Behavioural LIN bus: wired-AND of local transmit and remote nodes.
// Assumes a recessive-high bus pulled up inside the transceiver.
`timescale 1ns/100ps
`default_nettype none
module lftw_bus_model (
  // Local transmit
  input wire logic tx_pin,
  // Remote node forcing dominant
  input wire logic remote_low,
  // Level seen by the receiver
  output logic rx_pin
);
  // Pull-up returns a released bus to recessive
  assign rx_pin = tx_pin & ~remote_low;
endmodule
`default_nettype wire

// file: lftw_core.sv
// LIN fault supervision: dominant timeouts, bus-stuck and wakeup filter,
// bit-error abort, resync acceptance and interrupt gating.
// Assumes neighbours supply events, measurements and the TX bit stream.
// How it works
// - Resync needs break under 32 bits, 253952 cycles
// - New rate within fifty percent of current
// - Sync-valid status updated in resync mode
// - Polarity bit inverts transmit output
// - Four event interrupts gated by enables
// - Receive timeout is seventeen split bits
// - Receive fault exits break when enabled
// - Receive fault flag set, software clears
// - Transmit fault flag set, software clears
// - Transmit timeout value plus one fast ticks
// - Receive timeout value plus one fast ticks
// - Timeout faults may wake device
// - Stuck clear/active widths plus one slow ticks
// - Stuck condition flag, wakeup when enabled
// - Readback mismatch sets bit-error flag
// - Bit error with abort enable stops transmit
`timescale 1ns/100ps
`default_nettype none
module lftw_core
  import lftw_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Line
  input wire logic tx_data_in,
  input wire logic tx_active,
  input wire logic bit_sample,
  input wire logic rx_pin,
  output logic tx_pin,
  // Neighbour events and measurements
  input wire lftw_evt_type evt,
  input wire logic meas_valid,
  input wire logic [15:0] meas_rate,
  input wire logic [15:0] cur_rate,
  input wire logic [7:0] break_bits,
  input wire logic [17:0] break_cycles,
  // Results
  output logic rate_accept,
  output logic break_exit,
  output logic tx_abort,
  output logic rx_abort,
  output logic wake_req,
  output lftw_irq_type irq
);
  logic [7:0] cfg, tx_lo, tx_hi, rx_lo, rx_hi, clr_w, act_w, wkc, inten;
  logic [7:0] intf, next_intf;
  logic [7:0] next_cfg, next_tx_lo, next_tx_hi, next_rx_lo, next_rx_hi;
  logic [7:0] next_clr_w, next_act_w, next_wkc, next_inten, next_rdata;
  logic next_tx_pin, next_accept, next_brk, next_txab, next_rxab, next_wake;
  logic sync_valid, next_sync_valid, pol, next_pol;
  lftw_irq_type next_irq;
  logic [1:0] fdiv, next_fdiv;
  logic [8:0] sdiv, next_sdiv;
  logic fast_tick, slow_tick;
  logic [15:0] tx_cnt, next_tx_cnt, tx_to;
  logic [16:0] rx_cnt, next_rx_cnt, rx_to;
  logic tx_fired, next_tx_fired, rx_fired, next_rx_fired;
  logic [7:0] st_cnt, next_st_cnt;
  logic stuck, next_stuck, rx_prev;
  logic [4:0] wk_cnt, next_wk_cnt;
  logic tx_fault_evt, rx_fault_evt, stuck_evt, wake_evt, bit_mismatch_flag_evt;
  logic rate_ok;
  logic [17:0] m3, c2, m1;

  assign tx_to = {tx_hi, tx_lo};
  assign rx_to = {rx_hi, rx_lo, cfg[CFG_RX_TO0]};

  // Resync acceptance, divisor form of the rate window
  always_comb
  begin
    m3 = 18'(meas_rate) * 18'h0_0003;
    c2 = {1'b0, cur_rate, 1'b0};
    m1 = 18'(meas_rate);
    rate_ok = (break_bits < 8'(BREAK_MAX_BITS))
      && (break_cycles < 18'(BREAK_MAX_CYCLES))
      && (m3 >= c2) && (m1 <= c2);
  end

  // Oscillator tick dividers and fault timers
  always_comb
  begin
    next_fdiv = fdiv + 2'h1;
    fast_tick = (fdiv == 2'(FAST_DIV - 1));
    if (fast_tick)
      next_fdiv = 2'h0;
    next_sdiv = sdiv + 9'h001;
    slow_tick = (sdiv == 9'(SLOW_DIV - 1));
    if (slow_tick)
      next_sdiv = 9'h000;
    tx_fault_evt = 1'b0;
    rx_fault_evt = 1'b0;
    stuck_evt = 1'b0;
    wake_evt = 1'b0;
    next_tx_cnt = tx_cnt;
    next_tx_fired = tx_fired;
    next_rx_cnt = rx_cnt;
    next_rx_fired = rx_fired;
    next_st_cnt = st_cnt;
    next_stuck = stuck;
    next_wk_cnt = wk_cnt;
    if (tx_pin)
    begin
      next_tx_cnt = 16'h0000;
      next_tx_fired = 1'b0;
    end
    else if (fast_tick && !tx_fired)
    begin
      if (tx_cnt == tx_to)
      begin
        tx_fault_evt = 1'b1;
        next_tx_fired = 1'b1;
      end
      else
        next_tx_cnt = tx_cnt + 16'h0001;
    end
    if (rx_pin)
    begin
      next_rx_cnt = 17'h0_0000;
      next_rx_fired = 1'b0;
    end
    else if (fast_tick && !rx_fired)
    begin
      if (rx_cnt == rx_to)
      begin
        rx_fault_evt = 1'b1;
        next_rx_fired = 1'b1;
      end
      else
        next_rx_cnt = rx_cnt + 17'h0_0001;
    end
    // Stuck: dominant for active width, then recessive for clear width
    if (rx_pin == stuck)
    begin
      if (slow_tick)
      begin
        if (st_cnt == (stuck ? clr_w : act_w))
        begin
          next_stuck = !stuck;
          stuck_evt = !stuck;
          next_st_cnt = 8'h00;
        end
        else
          next_st_cnt = st_cnt + 8'h01;
      end
    end
    else
      next_st_cnt = 8'h00;
    // Wake filter saturates at sixteen ticks
    if (!rx_pin)
    begin
      if (slow_tick && wk_cnt != 5'h10)
        next_wk_cnt = wk_cnt + 5'h01;
    end
    else
    begin
      next_wk_cnt = 5'h00;
      if (!rx_prev && !stuck && wk_cnt > {1'b0, wkc[3:0]})
        wake_evt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fdiv <= 2'h0;
      sdiv <= 9'h000;
      tx_cnt <= 16'h0000;
      rx_cnt <= 17'h0_0000;
      tx_fired <= 1'b0;
      rx_fired <= 1'b0;
      st_cnt <= 8'h00;
      stuck <= 1'b0;
      wk_cnt <= 5'h00;
      rx_prev <= 1'b1;
    end
    else
    begin
      fdiv <= next_fdiv;
      sdiv <= next_sdiv;
      tx_cnt <= next_tx_cnt;
      rx_cnt <= next_rx_cnt;
      tx_fired <= next_tx_fired;
      rx_fired <= next_rx_fired;
      st_cnt <= next_st_cnt;
      stuck <= next_stuck;
      wk_cnt <= next_wk_cnt;
      rx_prev <= rx_pin;
    end
  end

  assign bit_mismatch_flag_evt = bit_sample && tx_active && (rx_pin != tx_pin);

  // Registers, flags and outputs; hardware set beats software clear
  always_comb
  begin
    next_cfg = cfg;
    next_tx_lo = tx_lo;
    next_tx_hi = tx_hi;
    next_rx_lo = rx_lo;
    next_rx_hi = rx_hi;
    next_clr_w = clr_w;
    next_act_w = act_w;
    next_wkc = wkc;
    next_inten = inten;
    next_intf = intf;
    next_pol = pol;
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_TO_CFG:
        begin
          next_cfg = reg_wdata;
          next_cfg[CFG_RX_FLAG] = cfg[CFG_RX_FLAG] & reg_wdata[CFG_RX_FLAG];
          next_cfg[CFG_TX_FLAG] = cfg[CFG_TX_FLAG] & reg_wdata[CFG_TX_FLAG];
        end
        ADDR_TX_TO_LO: next_tx_lo = reg_wdata;
        ADDR_TX_TO_HI: next_tx_hi = reg_wdata;
        ADDR_RX_TO_LO: next_rx_lo = reg_wdata;
        ADDR_RX_TO_HI: next_rx_hi = reg_wdata;
        ADDR_STUCK_CLR: next_clr_w = reg_wdata;
        ADDR_STUCK_ACT: next_act_w = reg_wdata;
        ADDR_STUCK_WKC:
        begin
          next_wkc = reg_wdata;
          next_wkc[7:6] = wkc[7:6] & reg_wdata[7:6];
        end
        ADDR_INT_EN:
        begin
          next_inten = reg_wdata;
          next_pol = reg_wdata[EN_POL_SYNC];
        end
        ADDR_INT_FLAGS:
        begin
          next_intf[INT_TX_ABORT] = reg_wdata[INT_TX_ABORT];
          next_intf[INT_RX_ABORT] = reg_wdata[INT_RX_ABORT];
          next_intf[INT_BIT_MISMATCH_FLAG] = intf[INT_BIT_MISMATCH_FLAG] & ~reg_wdata[INT_BIT_MISMATCH_FLAG];
          next_intf[3:0] = intf[3:0] & ~reg_wdata[3:0];
        end
        default: ;
      endcase
    end
    next_cfg[CFG_RX_FLAG] = next_cfg[CFG_RX_FLAG] | rx_fault_evt;
    next_cfg[CFG_TX_FLAG] = next_cfg[CFG_TX_FLAG] | tx_fault_evt;
    next_wkc[WKC_STUCK_FLAG] = next_wkc[WKC_STUCK_FLAG] | stuck_evt;
    next_wkc[WKC_BUS_FLAG] = next_wkc[WKC_BUS_FLAG] | wake_evt;
    next_intf[INT_BIT_MISMATCH_FLAG] = next_intf[INT_BIT_MISMATCH_FLAG] | bit_mismatch_flag_evt;
    next_intf[3:0] = next_intf[3:0] | evt;
    next_intf[7] = 1'b0;
    next_tx_pin = tx_data_in ^ pol;
    next_accept = meas_valid && inten[EN_RESYNC] && rate_ok;
    next_sync_valid = sync_valid;
    if (meas_valid && inten[EN_RESYNC])
      next_sync_valid = rate_ok;
    next_brk = rx_fault_evt && cfg[CFG_BRK_EXIT];
    next_txab = bit_mismatch_flag_evt && intf[INT_TX_ABORT];
    next_rxab = bit_mismatch_flag_evt && intf[INT_RX_ABORT];
    next_irq.autosync = intf[3] && inten[3];
    next_irq.break_sent = intf[2] && inten[2];
    next_irq.sync_recv = intf[1] && inten[1];
    next_irq.frame_ovf = intf[0] && inten[0];
    next_irq.bit_mismatch_flag = intf[INT_BIT_MISMATCH_FLAG] && inten[EN_BIT_MISMATCH_FLAG];
    next_irq.fault = (cfg[CFG_RX_FLAG] && cfg[CFG_RX_IEN])
      || (cfg[CFG_TX_FLAG] && cfg[CFG_TX_IEN]);
    next_irq.wake = (wkc[WKC_STUCK_FLAG] && wkc[WKC_STUCK_EN])
      || (wkc[WKC_BUS_FLAG] && wkc[WKC_BUS_EN]);
    next_wake = next_irq.wake
      || (rx_fault_evt && cfg[CFG_RX_WAKE])
      || (tx_fault_evt && cfg[CFG_TX_WAKE]);
    next_rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_TO_CFG: next_rdata = cfg;
        ADDR_TX_TO_LO: next_rdata = tx_lo;
        ADDR_TX_TO_HI: next_rdata = tx_hi;
        ADDR_RX_TO_LO: next_rdata = rx_lo;
        ADDR_RX_TO_HI: next_rdata = rx_hi;
        ADDR_STUCK_CLR: next_rdata = clr_w;
        ADDR_STUCK_ACT: next_rdata = act_w;
        ADDR_STUCK_WKC: next_rdata = wkc;
        ADDR_INT_EN:
        begin
          next_rdata = {1'b0, inten[6:0]};
          next_rdata[EN_POL_SYNC] = sync_valid;
        end
        ADDR_INT_FLAGS:
        begin
          next_rdata = {2'b00, rx_pin, 1'b0, intf[3:0]};
          next_rdata[INT_BIT_MISMATCH_FLAG] = intf[INT_BIT_MISMATCH_FLAG];
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg <= RESET_BYTE;
      tx_lo <= RESET_BYTE;
      tx_hi <= RESET_BYTE;
      rx_lo <= RESET_BYTE;
      rx_hi <= RESET_BYTE;
      clr_w <= RESET_BYTE;
      act_w <= RESET_BYTE;
      wkc <= RESET_BYTE;
      inten <= RESET_BYTE;
      intf <= RESET_BYTE;
      pol <= 1'b0;
      sync_valid <= 1'b0;
      reg_rdata <= 8'h00;
      tx_pin <= 1'b1;
      rate_accept <= 1'b0;
      break_exit <= 1'b0;
      tx_abort <= 1'b0;
      rx_abort <= 1'b0;
      wake_req <= 1'b0;
      irq <= '0;
    end
    else
    begin
      cfg <= next_cfg;
      tx_lo <= next_tx_lo;
      tx_hi <= next_tx_hi;
      rx_lo <= next_rx_lo;
      rx_hi <= next_rx_hi;
      clr_w <= next_clr_w;
      act_w <= next_act_w;
      wkc <= next_wkc;
      inten <= next_inten;
      intf <= next_intf;
      pol <= next_pol;
      sync_valid <= next_sync_valid;
      reg_rdata <= next_rdata;
      tx_pin <= next_tx_pin;
      rate_accept <= next_accept;
      break_exit <= next_brk;
      tx_abort <= next_txab;
      rx_abort <= next_rxab;
      wake_req <= next_wake;
      irq <= next_irq;
    end
  end

  // Independent tick count so the timeout check is not self-referential
  logic [16:0] chk_tx_ticks, next_chk_tx_ticks;

  always_comb
  begin
    next_chk_tx_ticks = chk_tx_ticks;
    if (tx_pin)
      next_chk_tx_ticks = 17'h0_0000;
    else if (fast_tick && chk_tx_ticks != 17'h1_FFFF)
      next_chk_tx_ticks = chk_tx_ticks + 17'h0_0001;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      chk_tx_ticks <= 17'h0_0000;
    else
      chk_tx_ticks <= next_chk_tx_ticks;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_tx_polarity: assert property (
    ##1 tx_pin == ($past(tx_data_in) ^ $past(pol)))
    else $error("tx pin polarity wrong");
  a_break_limit: assert property (
    rate_accept |-> $past(break_bits) < 8'(BREAK_MAX_BITS)
      && $past(break_cycles) < 18'(BREAK_MAX_CYCLES))
    else $error("rate accepted after long break");
  a_rate_window: assert property (
    rate_accept |-> {2'b00, $past(meas_rate)}
      <= {1'b0, $past(cur_rate), 1'b0}
      && 18'($past(meas_rate)) * 18'h0_0003
      >= {1'b0, $past(cur_rate), 1'b0})
    else $error("rate accepted outside window");
  a_sync_valid: assert property (
    meas_valid && inten[EN_RESYNC] |=> sync_valid == rate_accept)
    else $error("sync valid not updated");
  a_irq_gate: assert property (
    irq.frame_ovf |-> $past(inten[0]) && $past(intf[0]))
    else $error("ungated frame counter interrupt");
  a_rx_fault_flag: assert property (
    rx_fault_evt |=> cfg[CFG_RX_FLAG] ##1 irq.fault == ($past(cfg[CFG_RX_IEN])
      || $past(cfg[CFG_TX_FLAG] && cfg[CFG_TX_IEN])))
    else $error("rx fault flag or interrupt missing");
  a_tx_timeout: assert property (
    tx_fault_evt |-> !tx_pin && chk_tx_ticks == {1'b0, tx_to})
    else $error("tx fault at wrong count");
  a_counter_restart: assert property (
    rx_pin |=> rx_cnt == 17'h0_0000 && !rx_fired)
    else $error("rx counter not restarted");
  a_break_exit: assert property (
    rx_fault_evt && cfg[CFG_BRK_EXIT] |=> break_exit ##1 !break_exit)
    else $error("break exit pulse wrong");
  a_bit_mismatch_flag_abort: assert property (
    bit_mismatch_flag_evt && intf[INT_TX_ABORT] |=> tx_abort && intf[INT_BIT_MISMATCH_FLAG])
    else $error("bit error did not abort");

  c_rx_fault: cover property (rx_fault_evt ##1 break_exit);
  c_stuck_wake: cover property (stuck_evt ##[1:4] wake_req);
  c_bus_wake: cover property (wake_evt);
  c_accept: cover property (rate_accept && sync_valid);
endmodule
`default_nettype wire

// file: lftw_pkg.sv
// Constants and carrier types for the LIN fault, timeout and wakeup block.
// Assumes a 40 MHz reference clock and byte-wide register access.
package lftw_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int FAST_OSC_HZ = 16_000_000;
  localparam int SLOW_OSC_HZ = 128_000;
  // Tick dividers round down, so ticks run fast: the fast tick by a quarter, the slow tick slightly
  localparam int FAST_DIV = CLK_HZ / FAST_OSC_HZ;
  localparam int SLOW_DIV = CLK_HZ / SLOW_OSC_HZ;
  localparam int BREAK_MAX_BITS = 32;
  localparam int BREAK_MAX_CYCLES = 253952;
  localparam logic [15:0] ADDR_INT_FLAGS = 16'hA095;
  localparam logic [15:0] ADDR_INT_EN = 16'hA096;
  localparam logic [15:0] ADDR_TO_CFG = 16'hA0B0;
  localparam logic [15:0] ADDR_TX_TO_LO = 16'hA0B1;
  localparam logic [15:0] ADDR_TX_TO_HI = 16'hA0B2;
  localparam logic [15:0] ADDR_RX_TO_LO = 16'hA0B3;
  localparam logic [15:0] ADDR_RX_TO_HI = 16'hA0B4;
  localparam logic [15:0] ADDR_STUCK_CLR = 16'hA0B5;
  localparam logic [15:0] ADDR_STUCK_ACT = 16'hA0B6;
  localparam logic [15:0] ADDR_STUCK_WKC = 16'hA0B7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Timeout config fields
  localparam int CFG_RX_TO0 = 7;
  localparam int CFG_BRK_EXIT = 6;
  localparam int CFG_RX_WAKE = 5;
  localparam int CFG_TX_WAKE = 4;
  localparam int CFG_RX_FLAG = 3;
  localparam int CFG_TX_FLAG = 2;
  localparam int CFG_RX_IEN = 1;
  localparam int CFG_TX_IEN = 0;
  // Stuck/wakeup config fields
  localparam int WKC_STUCK_FLAG = 7;
  localparam int WKC_BUS_FLAG = 6;
  localparam int WKC_STUCK_EN = 5;
  localparam int WKC_BUS_EN = 4;
  // Interrupt flag / enable register fields
  localparam int INT_BIT_MISMATCH_FLAG = 6;
  localparam int INT_TX_ABORT = 5;
  localparam int INT_RX_ABORT = 4;
  localparam int INT_LINE = 5;
  localparam int EN_BIT_MISMATCH_FLAG = 6;
  localparam int EN_RESYNC = 5;
  localparam int EN_POL_SYNC = 4;

  typedef struct packed {
    logic autosync;
    logic break_sent;
    logic sync_recv;
    logic frame_ovf;
  } lftw_evt_type;

  typedef struct packed {
    logic autosync;
    logic break_sent;
    logic sync_recv;
    logic frame_ovf;
    logic bit_mismatch_flag;
    logic fault;
    logic wake;
  } lftw_irq_type;
endpackage

// file: lin_fault_timeout_wakeup_test.sv
// Self-checking bench for the LIN fault, timeout and wakeup core.
// Assumes the register map and tick rates of the package and notes.
`timescale 1ns/100ps
`default_nettype none
module lin_fault_timeout_wakeup_test;
  import lftw_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tx_data_in = 1'b1;
  logic tx_active = 1'b0;
  logic bit_sample = 1'b0;
  logic remote_low = 1'b0;
  logic meas_valid = 1'b0;
  logic [15:0] meas_rate = 16'h0000;
  logic [15:0] cur_rate = 16'h0001;
  logic [7:0] break_bits = 8'h00;
  logic [17:0] break_cycles = 18'h0_0000;
  lftw_evt_type evt = '0;
  lftw_irq_type irq;
  logic [7:0] reg_rdata, d;
  logic rx_pin, tx_pin, rate_accept, break_exit, tx_abort, rx_abort;
  logic wake_req, b, e, sv, be_seen, wk_seen;
  logic [3:0] en;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int i, n, m, c, bb, bc;

  always #12.5 ref_clk = ~ref_clk;

  lftw_core u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_data_in(tx_data_in), .tx_active(tx_active),
    .bit_sample(bit_sample), .rx_pin(rx_pin), .tx_pin(tx_pin), .evt(evt),
    .meas_valid(meas_valid), .meas_rate(meas_rate), .cur_rate(cur_rate),
    .break_bits(break_bits), .break_cycles(break_cycles),
    .rate_accept(rate_accept), .break_exit(break_exit),
    .tx_abort(tx_abort), .rx_abort(rx_abort), .wake_req(wake_req),
    .irq(irq));
  lftw_bus_model u_bus (.tx_pin(tx_pin), .remote_low(remote_low),
    .rx_pin(rx_pin));

  task report_and_stop();
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk8(input string nm, input logic [7:0] x, input logic [7:0] g);
    cmp_count++;
    if (g !== x)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask

  task chkb(input string nm, input logic x, input logic g);
    cmp_count++;
    if (g !== x)
    begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", nm, x, g);
    end
  endtask

  task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task rdchk(input logic [15:0] a, input logic [7:0] x);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    chk8($sformatf("reg %h", a), x, d);
  endtask

  // Edges from line going dominant until the fault interrupt shows
  task wait_fault();
    n = 0;
    be_seen = 1'b0;
    wk_seen = 1'b0;
    while (irq.fault !== 1'b1 && n < 400)
    begin
      @(posedge ref_clk);
      #1;
      n++;
      be_seen = be_seen | (break_exit === 1'b1);
      wk_seen = wk_seen | (wake_req === 1'b1);
    end
  endtask

  // Dominant for k cycles, then released for r cycles
  task hold_low(input int k, input int r);
    @(posedge ref_clk);
    remote_low <= 1'b1;
    repeat (k) @(posedge ref_clk);
    remote_low <= 1'b0;
    repeat (r) @(posedge ref_clk);
  endtask

  function automatic logic rate_ok(int mm, int cc, int nb, int nc);
    return nb < BREAK_MAX_BITS && nc < BREAK_MAX_CYCLES &&
      3 * mm >= 2 * cc && mm <= 2 * cc;
  endfunction

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  initial
  begin
    void'($urandom(75));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk(ADDR_INT_FLAGS, 8'h20);
    rdchk(ADDR_INT_EN, 8'h00);
    for (i = 0; i < 9; i++)
      rdchk(ADDR_TO_CFG + 16'(i), RESET_BYTE);
    for (i = 1; i < 9; i++)
    begin
      d = 8'($urandom);
      wr(ADDR_TO_CFG + 16'(i), d);
      if (i == 7)
        d = d & 8'h3F;
      rdchk(ADDR_TO_CFG + 16'(i), (i < 8) ? d : 8'h00);
    end
    // Random widths could fake a stuck bus in the short dominant tests
    wr(ADDR_STUCK_CLR, 8'h00);
    wr(ADDR_STUCK_ACT, 8'hFF);
    wr(ADDR_TO_CFG, 8'hFF);
    rdchk(ADDR_TO_CFG, 8'hF3);
    wr(ADDR_STUCK_WKC, 8'hFF);
    rdchk(ADDR_STUCK_WKC, 8'h3F);
    wr(ADDR_TO_CFG, 8'h00);
    wr(ADDR_STUCK_WKC, 8'h00);
    for (i = 0; i < 16; i++)
    begin
      if (i == 8)
        wr(ADDR_INT_EN, 8'h10);
      b = 1'($urandom);
      @(posedge ref_clk);
      tx_data_in <= b;
      @(posedge ref_clk);
      #1;
      chkb("tx_pin", b ^ (i >= 8), tx_pin);
    end
    tx_data_in <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      en = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : 4'($urandom);
      wr(ADDR_INT_EN, {4'h0, en});
      @(posedge ref_clk);
      evt <= lftw_evt_type'(4'hF);
      @(posedge ref_clk);
      evt <= '0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk8("irq_events", {4'h0, en}, {4'h0, irq[6:3]});
      wr(ADDR_INT_FLAGS, 8'h0F);
    end
    rdchk(ADDR_INT_FLAGS, 8'h20);
    wr(ADDR_INT_EN, 8'h20);
    for (i = 0; i < 12; i++)
    begin
      c = 100 + $urandom_range(3000);
      m = (i == 0) ? 2 * c : (i == 1) ? 2 * c + 1 : (i == 2) ?
        (2 * c + 2) / 3 : (i == 3) ? (2 * c + 2) / 3 - 1 : (i >= 10) ?
        c : c / 3 + $urandom_range(2 * c);
      bb = (i == 4) ? 32 : (i < 8) ? 31 : $urandom_range(40);
      bc = (i == 6) ? 253952 : (i < 8) ? 253951 : $urandom_range(260000);
      if (i == 11)
        wr(ADDR_INT_EN, 8'h00);
      e = rate_ok(m, c, bb, bc) && i != 11;
      if (i != 11)
        sv = e;
      @(posedge ref_clk);
      meas_rate <= 16'(m);
      cur_rate <= 16'(c);
      break_bits <= 8'(bb);
      break_cycles <= 18'(bc);
      meas_valid <= 1'b1;
      @(posedge ref_clk);
      meas_valid <= 1'b0;
      #1;
      chkb("rate_accept", e, rate_accept);
      d = (i == 11) ? 8'h00 : 8'h20;
      rdchk(ADDR_INT_EN, {3'h0, sv, 4'h0} | d);
    end
    wr(ADDR_INT_FLAGS, 8'h40);
    wr(ADDR_INT_FLAGS, 8'h30);
    wr(ADDR_INT_EN, 8'h40);
    for (i = 0; i < 2; i++)
    begin
      @(posedge ref_clk);
      tx_active <= 1'b1;
      remote_low <= (i == 1);
      bit_sample <= 1'b1;
      @(posedge ref_clk);
      bit_sample <= 1'b0;
      #1;
      chkb("tx_abort", i == 1, tx_abort);
      chkb("rx_abort", i == 1, rx_abort);
    end
    @(posedge ref_clk);
    remote_low <= 1'b0;
    tx_active <= 1'b0;
    #1;
    chkb("irq_bit_mismatch_flag", 1'b1, irq.bit_mismatch_flag);
    rdchk(ADDR_INT_FLAGS, 8'h60);
    wr(ADDR_INT_FLAGS, 8'h40);
    wr(ADDR_INT_EN, 8'h00);
    rdchk(ADDR_INT_FLAGS, 8'h20);
    wr(ADDR_RX_TO_LO, 8'h04);
    wr(ADDR_RX_TO_HI, 8'h00);
    wr(ADDR_TO_CFG, 8'hE2);
    hold_low(16, 4);
    rdchk(ADDR_TO_CFG, 8'hE2);
    @(posedge ref_clk);
    remote_low <= 1'b1;
    wait_fault();
    remote_low <= 1'b0;
    chkb("rx_to_time", 1'b1, n >= 20 && n <= 22);
    chkb("break_exit", 1'b1, be_seen);
    chkb("rx_wake", 1'b1, wk_seen);
    rdchk(ADDR_TO_CFG, 8'hEA);
    wr(ADDR_TO_CFG, 8'h11);
    wr(ADDR_TX_TO_LO, 8'h05);
    wr(ADDR_TX_TO_HI, 8'h00);
    @(posedge ref_clk);
    tx_data_in <= 1'b0;
    repeat (8) @(posedge ref_clk);
    tx_data_in <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rdchk(ADDR_TO_CFG, 8'h11);
    @(posedge ref_clk);
    tx_data_in <= 1'b0;
    wait_fault();
    tx_data_in <= 1'b1;
    chkb("tx_to_time", 1'b1, n >= 13 && n <= 15);
    chkb("tx_wake", 1'b1, wk_seen);
    rdchk(ADDR_TO_CFG, 8'h15);
    wr(ADDR_TO_CFG, 8'h00);
    rdchk(ADDR_TO_CFG, 8'h00);
    wr(ADDR_STUCK_ACT, 8'h1E);
    wr(ADDR_STUCK_WKC, 8'h13);
    hold_low(624, 10);
    rdchk(ADDR_STUCK_WKC, 8'h13);
    hold_low(1872, 10);
    rdchk(ADDR_STUCK_WKC, 8'h53);
    chkb("irq_wake", 1'b1, irq.wake);
    chkb("wake_req", 1'b1, wake_req);
    // Longest wake filter keeps the short pulse below bus wake
    wr(ADDR_STUCK_ACT, 8'h03);
    wr(ADDR_STUCK_WKC, 8'h2F);
    hold_low(600, 10);
    rdchk(ADDR_STUCK_WKC, 8'h2F);
    hold_low(1560, 10);
    rdchk(ADDR_STUCK_WKC, 8'hAF);
    chkb("irq_stuck", 1'b1, irq.wake);
    wr(ADDR_STUCK_WKC, 8'h2F);
    rdchk(ADDR_STUCK_WKC, 8'h2F);
    // Clear width zero rearms after one recessive slow tick
    repeat (400) @(posedge ref_clk);
    hold_low(1560, 10);
    rdchk(ADDR_STUCK_WKC, 8'hAF);
    report_and_stop();
  end
endmodule
`default_nettype wire
